/* File: inc/otc_pkg.sv */
// Purpose: shared constants and types for the overtemp config register bank
// Assumes: 8-bit register access port on the device's internal register bus
// Notes: temperatures are 8-bit raw codes in the selected format
package otc_pkg;
   localparam int OTC_AW = 8;
   localparam int OTC_DW = 8;
   localparam logic [7:0] OTC_FMT_ADDR = 8'h7C;
   localparam logic [7:0] OTC_PIN_ADDR = 8'h7D;
   localparam logic [7:0] OTC_FMT_RST = 8'h01;
   localparam logic [7:0] OTC_PIN_RST = 8'h00;
   // format register fields
   localparam int OTC_SIGNED_BIT = 0;
   localparam int OTC_OFSRNG_BIT = 1;
   localparam int OTC_CPU_EN_BIT = 4;
   localparam int OTC_REM1_EN_BIT = 5;
   localparam int OTC_LOCAL_EN_BIT = 6;
   localparam int OTC_REM2_EN_BIT = 7;
   // pin function register fields
   localparam int OTC_PINFN_LSB = 0;
   localparam int OTC_GDIS_BIT = 2;
   localparam int OTC_FANRSP_BIT = 3;
   localparam int OTC_BYP_LSB = 4;
   // limit codes meaning "disabled": -64 offset-64, -128 twos complement
   localparam logic [7:0] OTC_DIS_OFS64 = 8'h00;
   localparam logic [7:0] OTC_DIS_SIGNED = 8'h80;
   localparam logic [7:0] OTC_SIGN_FLIP = 8'h80;
   localparam logic [7:0] OTC_OFS64_BIAS = 8'h40;
   localparam int OTC_NCH = 4;

   typedef enum logic [1:0]
   {
      OTC_FN_FAN4_TACH = 2'b00,
      OTC_FN_OVERTEMP = 2'b01,
      OTC_FN_SMBALERT = 2'b10,
      OTC_FN_RESERVED = 2'b11
   } otc_pinfn_t;

   typedef struct packed
   {
      logic we;
      logic re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } otc_req_t;

   // channel order: 0 cpu, 1 remote1, 2 local, 3 remote2
   typedef struct packed
   {
      logic [3:0][7:0] temp;
      logic [3:0][7:0] limit;
   } otc_temps_t;
endpackage

/* File: rtl/otc_cmp.sv */
// Purpose: one channel's overtemperature compare in either number format
// Assumes: temp and limit are raw register codes, same format
// Notes: combinational; a disabled limit code never asserts
`timescale 1ns/1ps
module otc_cmp
   import otc_pkg::*;
(
   // format
   input wire logic signed_fmt_i,
   // operands
   input wire logic [7:0] temp_i,
   input wire logic [7:0] limit_i,
   // result
   output logic over_o
);
   logic [7:0] t_u;
   logic [7:0] l_u;
   logic dis;

   always_comb
   begin
      // map to unsigned ordering: flip sign for twos complement
      t_u = signed_fmt_i ? (temp_i ^ OTC_SIGN_FLIP) : temp_i; // RULE_01
      l_u = signed_fmt_i ? (limit_i ^ OTC_SIGN_FLIP) : limit_i; // RULE_01
      dis = signed_fmt_i ? (limit_i == OTC_DIS_SIGNED)
                         : (limit_i == OTC_DIS_OFS64); // RULE_09
      over_o = !dis && (t_u > l_u);
   end
endmodule

/* File: rtl/otc_regs.sv */
// Purpose: lockable format/overtemp-enable and pin-function config registers
// Assumes: single-cycle register port from the serial bus front end
// Notes: also drives the open-drain overtemp pin and fan response
//
// Function
// (RULE_01) format bit picks twos complement or offset-64
// (RULE_02) offset range bit sets sensor offset step
// (RULE_03) cpu offset always one degree per step
// (RULE_04) bit 4 enables cpu overtemp pin assertion
// (RULE_05) bit 5 enables remote 1 overtemp assertion
// (RULE_06) bit 6 enables local overtemp assertion
// (RULE_07) bit 7 enables remote 2 overtemp assertion
// (RULE_08) disabled channels never drive the pin
// (RULE_09) minimum limit code disables a channel
// (RULE_10) host sets timer limit max for output
// (RULE_11) lock makes both registers read-only
// (RULE_12) pin function code selects shared pin use
// (RULE_13) global disable suppresses every channel's output; code gates only the overtemp pin, fan response still follows
// (RULE_14) fan response: full duty or per-fan maximum
// (RULE_15) bits 4-7 bypass voltage input attenuators
// (RULE_16) format register resets to 0x01
// (RULE_17) pin is OR of enabled, gated channels
`timescale 1ns/1ps
module otc_regs
   import otc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // register port
   input wire otc_req_t req_i,
   input wire logic lock_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // temperatures and limits
   input wire otc_temps_t temps_i,
   // overtemp pin, open drain, active low on the wire
   input wire logic overtemp_pin_i,
   output logic overtemp_pin_o,
   output logic overtemp_pin_oe_n_o,
   output logic overtemp_timer_in_o,
   // configuration outputs
   output logic signed_format_select_o,
   output logic offset_half_step_o,
   output logic cpu_offset_full_step_o,
   output logic [1:0] pin_function_o,
   output logic fan4_speed_input_sel_o,
   output logic smbalert_sel_o,
   output logic fan_full_duty_o,
   output logic fan_max_duty_o,
   output logic [3:0] attenuator_bypass_o
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0] fmt_reg;
   logic [7:0] fmt_next;
   logic [7:0] pin_reg;
   logic [7:0] pin_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic [1:0] pin_s_reg;
   logic [1:0] pin_s_next;
   logic drive_reg;
   logic drive_next;
   logic over_any_reg;
   logic over_any_next;

   always_comb
   begin
      fmt_next = fmt_reg;
      pin_next = pin_reg;
      // writes after lock are dropped silently
      if (req_i.we && !lock_i) // RULE_11
      begin
         if (req_i.addr == OTC_FMT_ADDR)
         begin
            fmt_next = req_i.wdata;
         end
         if (req_i.addr == OTC_PIN_ADDR)
         begin
            pin_next = req_i.wdata;
         end
      end
      rvalid_next = req_i.re;
      rdata_next = rdata_reg;
      if (req_i.re)
      begin
         case (req_i.addr)
            OTC_FMT_ADDR: rdata_next = fmt_reg;
            OTC_PIN_ADDR: rdata_next = pin_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         fmt_reg <= OTC_FMT_RST; // RULE_16
         pin_reg <= OTC_PIN_RST;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         fmt_reg <= fmt_next;
         pin_reg <= pin_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign rvalid_o = rvalid_reg;

   // ************************************************************
   // configuration decode
   // ************************************************************
   // format changes take effect on the next compare, no resync needed
   assign signed_format_select_o = fmt_reg[OTC_SIGNED_BIT]; // RULE_01
   assign offset_half_step_o = !fmt_reg[OTC_OFSRNG_BIT]; // RULE_02
   assign cpu_offset_full_step_o = 1'b1; // RULE_03
   assign pin_function_o = pin_reg[OTC_PINFN_LSB +: 2]; // RULE_12
   assign fan4_speed_input_sel_o =
      (pin_function_o == OTC_FN_FAN4_TACH); // RULE_12
   assign smbalert_sel_o = (pin_function_o == OTC_FN_SMBALERT); // RULE_12
   assign attenuator_bypass_o = pin_reg[OTC_BYP_LSB +: 4]; // RULE_15

   // ************************************************************
   // channel compares
   // ************************************************************
   logic [OTC_NCH-1:0] ch_en;
   logic [OTC_NCH-1:0] ch_over;
   logic gated;

   assign ch_en[0] = fmt_reg[OTC_CPU_EN_BIT]; // RULE_04
   assign ch_en[1] = fmt_reg[OTC_REM1_EN_BIT]; // RULE_05
   assign ch_en[2] = fmt_reg[OTC_LOCAL_EN_BIT]; // RULE_06
   assign ch_en[3] = fmt_reg[OTC_REM2_EN_BIT]; // RULE_07

   genvar g;
   generate
      for (g = 0; g < OTC_NCH; g++)
      begin : g_ch
         otc_cmp u_cmp
         (
            .signed_fmt_i(signed_format_select_o),
            .temp_i(temps_i.temp[g]),
            .limit_i(temps_i.limit[g]),
            .over_o(ch_over[g])
         );
      end
   endgenerate

   assign gated = !pin_reg[OTC_GDIS_BIT] &&
                  (pin_function_o == OTC_FN_OVERTEMP); // RULE_13

   always_comb
   begin
      drive_next = gated && |(ch_en & ch_over); // RULE_08 RULE_17
      // fan response follows any limit exceeded, enabled or not
      over_any_next = |ch_over; // RULE_14
      pin_s_next = {pin_s_reg[0], overtemp_pin_i};
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         drive_reg <= 1'b0;
         over_any_reg <= 1'b0;
         pin_s_reg <= 2'b11;
      end
      else
      begin
         drive_reg <= drive_next;
         over_any_reg <= over_any_next;
         pin_s_reg <= pin_s_next;
      end
   end

   // open drain: pull low when asserting; timer always sees the wire
   assign overtemp_pin_o = 1'b0;
   assign overtemp_pin_oe_n_o = !drive_reg; // RULE_08
   // timer input counts every low on the wire, own drive included; host sets its limit
   // to maximum when the pin is used as an output
   assign overtemp_timer_in_o = !pin_s_reg[1]; // RULE_10
   assign fan_full_duty_o = over_any_reg &&
                            !pin_reg[OTC_FANRSP_BIT]; // RULE_14
   assign fan_max_duty_o = over_any_reg && pin_reg[OTC_FANRSP_BIT]; // RULE_14

   // ************************************************************
   // checks
   // ************************************************************
   sequence wr_fmt_s;
      req_i.we && req_i.addr == OTC_FMT_ADDR;
   endsequence

   sequence wr_pin_s;
      req_i.we && req_i.addr == OTC_PIN_ADDR;
   endsequence

   sequence rd_fmt_s;
      req_i.re && req_i.addr == OTC_FMT_ADDR;
   endsequence

   lock_hold_a: assert property ( // RULE_11
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      lock_i |=> $stable(fmt_reg) && $stable(pin_reg))
      else $error("locked register changed");

   fmt_write_a: assert property ( // RULE_01
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_fmt_s and !lock_i |=> fmt_reg == $past(req_i.wdata))
      else $error("format write not taken");

   pin_write_a: assert property ( // RULE_12
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_pin_s and !lock_i |=> pin_reg == $past(req_i.wdata))
      else $error("pin function write not taken");

   offset_step_a: assert property ( // RULE_02
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_fmt_s and !lock_i
      |=> offset_half_step_o == !$past(req_i.wdata[OTC_OFSRNG_BIT]))
      else $error("offset step select not taken");

   bypass_set_a: assert property ( // RULE_15
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_pin_s and !lock_i
      |=> attenuator_bypass_o == $past(req_i.wdata[OTC_BYP_LSB +: 4]))
      else $error("attenuator bypass not taken");

   read_back_a: assert property ( // RULE_16
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      rd_fmt_s |=> rvalid_o && rdata_o == $past(fmt_reg))
      else $error("format read back wrong");

   reset_val_a: assert property ( // RULE_16
      @(posedge ref_clk_i)
      sys_rst_i |=> fmt_reg == OTC_FMT_RST)
      else $error("format reset value wrong");

   gdis_off_a: assert property ( // RULE_13
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      pin_reg[OTC_GDIS_BIT] |=> overtemp_pin_oe_n_o)
      else $error("pin driven while globally disabled");

   no_enable_a: assert property ( // RULE_08
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      ch_en == 4'h0 |=> overtemp_pin_oe_n_o)
      else $error("pin driven with no channel enabled");

   drive_off_a: assert property ( // RULE_08
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      !(|(ch_en & ch_over)) |=> overtemp_pin_oe_n_o)
      else $error("pin driven with no enabled channel over");

   cpu_drive_a: assert property ( // RULE_04
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      gated && ch_en[0] && ch_over[0] |=> !overtemp_pin_oe_n_o)
      else $error("cpu overtemp not driven");

   rem1_drive_a: assert property ( // RULE_05
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      gated && ch_en[1] && ch_over[1] |=> !overtemp_pin_oe_n_o)
      else $error("remote1 overtemp not driven");

   local_drive_a: assert property ( // RULE_06
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      gated && ch_en[2] && ch_over[2] |=> !overtemp_pin_oe_n_o)
      else $error("local overtemp not driven");

   rem2_drive_a: assert property ( // RULE_07
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      gated && ch_en[3] && ch_over[3] |=> !overtemp_pin_oe_n_o)
      else $error("remote2 overtemp not driven");

   dis_limit_a: assert property ( // RULE_09
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      signed_format_select_o && temps_i.limit[1] == OTC_DIS_SIGNED
      |-> !ch_over[1])
      else $error("disabled limit asserted");

   dis_ofs64_a: assert property ( // RULE_09
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      !signed_format_select_o && temps_i.limit[2] == OTC_DIS_OFS64
      |-> !ch_over[2])
      else $error("disabled offset-64 limit asserted");

   fan_mode_a: assert property ( // RULE_14
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (|ch_over) |=> fan_full_duty_o != fan_max_duty_o)
      else $error("fan response not exactly one mode");

   fan_idle_a: assert property ( // RULE_14
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      !(|ch_over) |=> !fan_full_duty_o && !fan_max_duty_o)
      else $error("fan response without any limit exceeded");

   timer_sync_a: assert property ( // RULE_10
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      !overtemp_pin_i |=> ##1 overtemp_timer_in_o)
      else $error("timer input missed a low wire");

   pin_fn_a: assert property ( // RULE_17
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      pin_function_o != OTC_FN_OVERTEMP |=> overtemp_pin_oe_n_o)
      else $error("pin driven outside overtemp function");
endmodule

/* File: bench/otc_partner.sv */
// Purpose: open-drain overtemp wire with pull-up and an outside puller
// Assumes: the pull-up holds the wire high while nobody pulls it low
// Notes: the outside party may pull low at any time
`timescale 1ns/1ps
module otc_partner
(
   // design side
   input wire logic pin_i,
   input wire logic pin_oe_n_i,
   // outside driver
   input wire logic ext_low_i,
   // wire level
   output logic wire_o
);
   // host keeps the timer limit at max while the pin is an output
   logic [7:0] assertion_timer_limit;
   assign assertion_timer_limit = 8'hFF;
   assign wire_o = !((!pin_oe_n_i && !pin_i) || ext_low_i);
endmodule

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the overtemp config registers
// Assumes: one-cycle register port, reads answered one cycle later
// Notes: table rows cover the pin gating; lock and reset are hand-written
`timescale 1ns/1ps
module tb_top
   import otc_pkg::*;
;
   typedef struct packed
   {
      logic [7:0] f;
      logic [7:0] p;
      logic [31:0] t;
      logic [31:0] l;
      logic o;
      logic u;
      logic m;
      logic c;
   } otc_row_t;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   otc_req_t req = '0;
   logic lock = 1'b0;
   logic ext_low = 1'b0;
   otc_temps_t temps = '0;
   logic [7:0] rdata;
   logic rvalid, pin_o, oe_n, tmr, sfs, ohs, cfs, f4, sa, ffd, fmd, lvl;
   logic [1:0] pfn;
   logic [3:0] byp;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   otc_row_t rows [13] = '{
      '{8'h11, 8'h01, 32'h0000_0010, 32'h8080_800F, 1'b0, 1'b1, 1'b0, 1'b1},
      '{8'h21, 8'h01, 32'h0000_0010, 32'h8080_800F, 1'b1, 1'b1, 1'b0, 1'b1},
      '{8'h21, 8'h01, 32'h0000_0500, 32'h8080_FB80, 1'b0, 1'b1, 1'b0, 1'b1},
      '{8'h22, 8'h01, 32'h0000_0500, 32'h0000_FB00, 1'b1, 1'b0, 1'b0, 1'b1},
      '{8'h41, 8'h01, 32'h0030_0000, 32'h8080_8080, 1'b1, 1'b0, 1'b0, 1'b1},
      '{8'h40, 8'h01, 32'h0030_0000, 32'h0000_0000, 1'b1, 1'b0, 1'b0, 1'b1},
      '{8'h41, 8'h01, 32'h0030_0000, 32'h8020_8080, 1'b0, 1'b1, 1'b0, 1'b1},
      '{8'h81, 8'h09, 32'h5000_0000, 32'h4080_8080, 1'b0, 1'b0, 1'b1, 1'b1},
      '{8'h81, 8'h05, 32'h5000_0000, 32'h4080_8080, 1'b1, 1'b0, 1'b0, 1'b0},
      '{8'h81, 8'h00, 32'h5000_0000, 32'h4080_8080, 1'b1, 1'b1, 1'b0, 1'b1},
      '{8'h81, 8'hF2, 32'h5000_0000, 32'h4080_8080, 1'b1, 1'b1, 1'b0, 1'b1},
      '{8'h81, 8'h03, 32'h5000_0000, 32'h4080_8080, 1'b1, 1'b1, 1'b0, 1'b1},
      '{8'h81, 8'h01, 32'h4000_0000, 32'h4080_8080, 1'b1, 1'b0, 1'b0, 1'b1}};
   always #50 ref_clk_i = ~ref_clk_i;
   otc_regs otc_regs_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .req_i(req), .lock_i(lock), .rdata_o(rdata), .rvalid_o(rvalid),
      .temps_i(temps), .overtemp_pin_i(lvl), .overtemp_pin_o(pin_o),
      .overtemp_pin_oe_n_o(oe_n), .overtemp_timer_in_o(tmr),
      .signed_format_select_o(sfs), .offset_half_step_o(ohs),
      .cpu_offset_full_step_o(cfs), .pin_function_o(pfn),
      .fan4_speed_input_sel_o(f4), .smbalert_sel_o(sa),
      .fan_full_duty_o(ffd), .fan_max_duty_o(fmd),
      .attenuator_bypass_o(byp));
   otc_partner otc_partner_i (.pin_i(pin_o), .pin_oe_n_i(oe_n),
      .ext_low_i(ext_low), .wire_o(lvl));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i) #1 req = '{1'b1, 1'b0, a, d};
      @(posedge ref_clk_i) #1 req = '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_i) #1 req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk_i) #1 req = '0;
      chk({rvalid, rdata}, {1'b1, e});
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic reset_check();
      sys_rst_i = 1'b1;
      wait_n(4);
      sys_rst_i = 0;
      chk({oe_n, ffd, fmd, rvalid}, 4'h8);
      rd(OTC_FMT_ADDR, 8'h01);
      rd(OTC_PIN_ADDR, 8'h00);
   endtask
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      reset_check();
      foreach (rows[k])
      begin
         temps = {rows[k].t, rows[k].l};
         wr(OTC_FMT_ADDR, rows[k].f);
         wr(OTC_PIN_ADDR, rows[k].p);
         wait_n(3);
         chk(oe_n, rows[k].o);
         chk({pin_o, lvl, tmr},
            {1'b0, rows[k].o, !rows[k].o});
         if (rows[k].c)
            chk({ffd, fmd}, {rows[k].u, rows[k].m});
         chk({sfs, ohs, cfs},
            {rows[k].f[0], !rows[k].f[1], 1'b1});
         chk({pfn, f4, sa}, {rows[k].p[1:0], rows[k].p[1:0] == 2'b00,
            rows[k].p[1:0] == 2'b10});
         chk(byp, rows[k].p[7:4]);
         rd(OTC_FMT_ADDR, rows[k].f);
      end
      rd(8'h7E, 8'h00);
      lock = 1'b1;
      wr(OTC_FMT_ADDR, 8'h00);
      wr(OTC_PIN_ADDR, 8'h00);
      rd(OTC_FMT_ADDR, 8'h81);
      rd(OTC_PIN_ADDR, 8'h01);
      lock = 1'b0;
      wr(OTC_PIN_ADDR, 8'h00);
      ext_low = 1'b1;
      wait_n(3);
      chk({oe_n, tmr}, 2'b11);
      ext_low = 1'b0;
      wait_n(3);
      chk(tmr, 1'b0);
      reset_check();
      report_and_stop();
   end
endmodule
